// ===== design/rcv_pkg.sv
// Purpose: constants for the room climate value reporter
// Assumes: 25 MHz system clock, values as signed/unsigned binary
// Notes: times given in their own unit, cycle counts derived
package rcv_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int SEC_TICKS = 10;
  localparam int MIN_TICKS = 600;
  localparam int HUM_DELAY_S = 10;
  localparam int HUM_DELAY_TICKS = HUM_DELAY_S * SEC_TICKS;
  localparam int HUM_CYC_UNIT_S = 10;
  localparam logic [3:0] WEIGHT_RST = 4'h5;
  localparam logic [7:0] CAL_RST = 8'h00;
  localparam logic [7:0] TEMP_DELTA_RST = 8'h03;
  localparam logic [7:0] TEMP_CYC_RST = 8'h0f;
  localparam logic [2:0] HUM_THR_RST = 3'h3;
  typedef enum logic [1:0] {
    SRC_INTERNAL, SRC_RECEIVED, SRC_BOTH
  } rcv_src_t;
  typedef enum logic [2:0] {
    PA_NONE, PA_SEND_ON, PA_SEND_OFF, PA_SET_ON, PA_SET_OFF
  } rcv_pact_t;
  typedef enum logic [2:0] {
    OM_COMFORT, OM_STANDBY, OM_NIGHT, OM_PROTECT
  } rcv_mode_t;
endpackage

// ===== design/rcv_timer.sv
`timescale 1ns/10ps
// Purpose: interval counter on 100 ms ticks
// Assumes: tick is a one-cycle pulse
// Notes: period zero holds the counter at zero and never fires
module rcv_timer #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic restart,
  input wire logic [W-1:0] period,
  output logic fire
);
  if (W < 8) begin : g_bad_width
    $error("timer width too small");
  end
  logic [W-1:0] cnt_r, cnt_nxt;
  logic fire_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    fire_nxt = 1'b0;
    if (restart || period == '0) begin
      cnt_nxt = '0;
    end else if (tick) begin
      if (cnt_r + 1'b1 >= period) begin
        cnt_nxt = '0;
        fire_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_r <= '0;
      fire <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      fire <= fire_nxt;
    end
  end
endmodule

// ===== design/rcv_reporter.sv
`timescale 1ns/10ps
// Purpose: temperature blending and humidity reporting with limits
// Assumes: temperatures signed 0.1 K, humidity in 0.1 percent RH
// Notes: limit hysteresis and limit delays are handled elsewhere, the humidity send delay is counted here
module rcv_reporter (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire rcv_pkg::rcv_src_t tempSrc,
  input wire logic [3:0] blendWeight,
  input wire logic [7:0] rxCalib,
  input wire logic [7:0] pollMin,
  input wire logic [7:0] tempDelta,
  input wire logic [7:0] tempCycMin,
  input wire logic [15:0] intTemp,
  input wire logic [15:0] rxTemp,
  input wire logic rxTempValid,
  input wire logic [9:0] humValue,
  input wire logic [2:0] humThrSel,
  input wire logic [6:0] humCycSet,
  input wire logic [1:0] limitCount,
  input wire logic [1:0] limitEval,
  input wire rcv_pkg::rcv_mode_t ctrlMode,
  input wire logic coolingOp,
  input wire rcv_pkg::rcv_pact_t actHeat,
  input wire rcv_pkg::rcv_pact_t actCool,
  output logic [15:0] roomTemp,
  output logic ctrlEnable,
  output logic tempSend,
  output logic pollReq,
  output logic humSend,
  output logic [1:0] limitState,
  output logic [1:0] limitSend
);
  import rcv_pkg::*;
  // ************************************************************
  // time base
  // ************************************************************
  logic [21:0] pre_r, pre_nxt;
  logic tick_r, tick_nxt;
  always_comb begin
    tick_nxt = 1'b0;
    pre_nxt = pre_r + 22'h1;
    if (pre_r == 22'(TICK_CYC - 1)) begin
      pre_nxt = '0;
      tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pre_r <= '0;
      tick_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      tick_r <= tick_nxt;
    end
  end
  // ************************************************************
  // temperature source
  // ************************************************************
  function automatic logic [15:0] absDiff(input logic [15:0] a,
                                          input logic [15:0] b);
    logic signed [16:0] d;
    d = 17'(signed'(a)) - 17'(signed'(b));
    absDiff = d[16] ? 16'(-d) : d[15:0];
  endfunction
  logic signed [15:0] calTemp;
  logic signed [21:0] mix;
  logic [3:0] wInt;
  logic [15:0] curTemp;
  // received value held between telegrams
  logic [15:0] rxHeld_r, rxHeld_nxt;
  assign calTemp = signed'(rxHeld_r) + 16'(signed'(rxCalib));
  // weight 1..9 selects internal share in tenths
  assign wInt = (blendWeight >= 4'h1 && blendWeight <= 4'h9)
    ? blendWeight : WEIGHT_RST;
  always_comb begin
    mix = 22'(signed'(intTemp)) * signed'(22'(wInt))
        + 22'(calTemp) * signed'(22'(4'ha - wInt));
    unique case (tempSrc)
      SRC_INTERNAL: curTemp = intTemp;
      SRC_RECEIVED: curTemp = calTemp;
      default: curTemp = 16'(mix / 22'sd10);
    endcase
  end
  logic gotRx_r, gotRx_nxt, ctrl_nxt;
  always_comb begin
    gotRx_nxt = gotRx_r | rxTempValid;
    rxHeld_nxt = rxTempValid ? rxTemp : rxHeld_r;
    // internal-only starts at once others wait
    ctrl_nxt = (tempSrc == SRC_INTERNAL) || gotRx_nxt;
  end
  logic pollFire, tcFire, hcFire;
  // 255 minutes of ticks needs 18 bits
  rcv_timer #(.W(18)) u_poll (
    .clk_sys(clk_sys), .rst_n(rst_n), .tick(tick_r),
    .restart(tempSrc == SRC_INTERNAL),
    .period(18'(pollMin) * 18'(MIN_TICKS)),
    .fire(pollFire)
  );
  rcv_timer #(.W(18)) u_tcyc (
    .clk_sys(clk_sys), .rst_n(rst_n), .tick(tick_r), .restart(tempSend),
    .period(18'(tempCycMin) * 18'(MIN_TICKS)),
    .fire(tcFire)
  );
  rcv_timer #(.W(16)) u_hcyc (
    .clk_sys(clk_sys), .rst_n(rst_n), .tick(tick_r), .restart(1'b0),
    .period(16'(humCycSet) * 16'(HUM_CYC_UNIT_S * SEC_TICKS)),
    .fire(hcFire)
  );
  logic [15:0] lastTemp_r, lastTemp_nxt;
  logic tSend_nxt;
  always_comb begin
    tSend_nxt = ctrl_nxt && (tcFire || (tempDelta != 8'h00 &&
      absDiff(curTemp, lastTemp_r) >= 16'(tempDelta)));
    lastTemp_nxt = tSend_nxt ? curTemp : lastTemp_r;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gotRx_r <= 1'b0;
      rxHeld_r <= '0;
      ctrlEnable <= 1'b0;
      roomTemp <= '0;
      lastTemp_r <= '0;
      tempSend <= 1'b0;
      pollReq <= 1'b0;
    end else begin
      gotRx_r <= gotRx_nxt;
      rxHeld_r <= rxHeld_nxt;
      ctrlEnable <= ctrl_nxt;
      roomTemp <= curTemp;
      lastTemp_r <= lastTemp_nxt;
      tempSend <= tSend_nxt;
      pollReq <= pollFire;
    end
  end
  // ************************************************************
  // humidity change reporting
  // ************************************************************
  logic [9:0] thr;
  always_comb begin
    unique case (humThrSel)
      3'h1: thr = 10'h005;
      3'h2: thr = 10'h00a;
      3'h3: thr = 10'h01e;
      3'h4: thr = 10'h064;
      default: thr = 10'h000;
    endcase
  end
  logic [9:0] lastHum_r, lastHum_nxt;
  logic [6:0] hdly_r, hdly_nxt;
  logic hSend_nxt, hChg;
  always_comb begin
    hChg = thr != 10'h000 &&
      absDiff(16'(humValue), 16'(lastHum_r)) >= 16'(thr);
    hdly_nxt = hdly_r;
    hSend_nxt = hcFire;
    if (hdly_r != 7'h00) begin
      if (tick_r) hdly_nxt = hdly_r - 7'h01;
    end else if (hChg) begin
      hSend_nxt = 1'b1;
      hdly_nxt = 7'(HUM_DELAY_TICKS);
    end
    lastHum_nxt = hSend_nxt ? humValue : lastHum_r;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lastHum_r <= '0;
      hdly_r <= '0;
      humSend <= 1'b0;
    end else begin
      lastHum_r <= lastHum_nxt;
      hdly_r <= hdly_nxt;
      humSend <= hSend_nxt;
    end
  end
  // ************************************************************
  // limit values and protection handling
  // ************************************************************
  logic [1:0] limEn;
  assign limEn = (limitCount == 2'h0) ? 2'b00 :
                 (limitCount == 2'h1) ? 2'b01 : 2'b11;
  logic prot, prot_r, cool_r;
  rcv_pact_t act;
  logic [1:0] lim_nxt, lsend_nxt;
  assign prot = ctrlMode == OM_PROTECT;
  assign act = coolingOp ? actCool : actHeat;
  always_comb begin
    lim_nxt = limitState;
    lsend_nxt = 2'b00;
    if (prot && (!prot_r || coolingOp != cool_r)) begin
      unique case (act)
        PA_SEND_ON: begin
          lim_nxt = limEn;
          lsend_nxt = limEn;
        end
        PA_SEND_OFF: begin
          lim_nxt = 2'b00;
          lsend_nxt = limEn;
        end
        PA_SET_ON: lim_nxt = limEn;
        PA_SET_OFF: lim_nxt = 2'b00;
        default: lim_nxt = limitEval & limEn;
      endcase
    end else if (!prot || act == PA_NONE) begin
      lim_nxt = limitEval & limEn;
      lsend_nxt = (lim_nxt ^ limitState) & limEn;
    end
    if (hcFire) lsend_nxt = limEn;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prot_r <= 1'b0;
      cool_r <= 1'b0;
      limitState <= 2'b00;
      limitSend <= 2'b00;
    end else begin
      prot_r <= prot;
      cool_r <= coolingOp;
      limitState <= lim_nxt;
      limitSend <= lsend_nxt;
    end
  end
  // ************************************************************
  // checks
  // ************************************************************
  a_ctrl_internal: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tempSrc == SRC_INTERNAL |=> ctrlEnable)
    else $error("control not started for internal source");
  a_ctrl_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !gotRx_r && !rxTempValid && tempSrc != SRC_INTERNAL |=> !ctrlEnable)
    else $error("control started without telegram");
  a_prot_send_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
    prot && !prot_r && act == PA_SEND_ON |=> limitState == limEn
    && limitSend == limEn) else $error("send on not applied");
  a_prot_silent: assert property (@(posedge clk_sys) disable iff (!rst_n)
    prot && !prot_r && act == PA_SET_OFF && !hcFire |=> limitState == 2'b00
    && limitSend == 2'b00) else $error("silent off wrong");
  sequence s_held;
    prot && prot_r && coolingOp == cool_r && act != PA_NONE;
  endsequence
  a_prot_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_held |=> $stable(limitState)) else $error("limit moved");
  a_lim_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    limitCount == 2'h0 ##1 limitCount == 2'h0 |-> limitState == 2'b00)
    else $error("limit with none enabled");
  a_temp_ref: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tempSend |-> lastTemp_r == roomTemp) else $error("ref stale");
  a_hum_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hdly_r != 7'h00 && !hcFire |=> !humSend)
    else $error("humidity sent inside delay");
  a_poll_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pollMin == 8'h00 [*2] |=> !pollReq)
    else $error("poll with interval zero");
  a_rx_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rxTempValid |=> rxHeld_r == $past(rxTemp))
    else $error("received value not held");
endmodule

// ===== testbench/rcv_thermo_model.sv
// Purpose: bus thermostat feeding the received temperature
// Assumes: one telegram is a one-cycle valid pulse
// Notes: value line shows the inverse between telegrams
`timescale 1ns/10ps
module rcv_thermo_model (
  input wire logic clk_sys,
  input wire logic pollReq,
  input wire logic sendNow,
  input wire logic [15:0] tempVal,
  output logic [15:0] rxTemp,
  output logic rxTempValid
);
  logic [2:0] waitCnt_r = 3'h0;
  initial begin
    rxTemp = 16'h0000;
    rxTempValid = 1'b0;
  end
  // ****
  // answer a poll late, or push on its own
  // ****
  always @(posedge clk_sys) begin
    rxTempValid <= 1'b0;
    rxTemp <= ~tempVal;
    if (pollReq) begin
      waitCnt_r <= 3'h3;
    end else if (waitCnt_r != 3'h0) begin
      waitCnt_r <= waitCnt_r - 3'h1;
    end
    if (sendNow || waitCnt_r == 3'h1) begin
      rxTempValid <= 1'b1;
      rxTemp <= tempVal;
    end
  end
endmodule

// ===== testbench/tb_room_climate_value_reporter.sv
// Purpose: self-checking bench of the climate reporter
// Assumes: minute and second timers too long to run here
// Notes: temperatures in 0.1 K, internal 200, received 300
`timescale 1ns/10ps
module tb_room_climate_value_reporter;
  import rcv_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  rcv_src_t tempSrc = SRC_INTERNAL;
  logic [3:0] blendWeight = WEIGHT_RST;
  logic [7:0] rxCalib = CAL_RST;
  logic [7:0] pollMin = 8'h00;
  logic [7:0] tempDelta = TEMP_DELTA_RST;
  logic [7:0] tempCycMin = TEMP_CYC_RST;
  logic [15:0] intTemp = 16'h00c8;
  logic sendNow = 1'b0;
  logic [9:0] humValue = 10'h1f4;
  logic [2:0] humThrSel = HUM_THR_RST;
  logic [6:0] humCycSet = 7'h00;
  logic [1:0] limitCount = 2'h2;
  logic [1:0] limitEval = 2'h1;
  rcv_mode_t ctrlMode = OM_COMFORT;
  logic coolingOp = 1'b0;
  rcv_pact_t actHeat = PA_NONE;
  rcv_pact_t actCool = PA_SET_OFF;
  logic [15:0] roomTemp, rxTemp;
  logic ctrlEnable, tempSend, pollReq, humSend, rxTempValid;
  logic [1:0] limitState, limitSend;
  int fail_count = 0;
  int checks_done = 0;
  int sends = 0;
  int hsends = 0;
  int polls = 0;
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (tempSend === 1'b1) sends <= sends + 1;
  always @(posedge clk_sys) if (humSend === 1'b1) hsends <= hsends + 1;
  always @(posedge clk_sys) if (pollReq !== 1'b0) polls <= polls + 1;
  rcv_reporter u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .tempSrc(tempSrc), .blendWeight(blendWeight), .rxCalib(rxCalib),
    .pollMin(pollMin), .tempDelta(tempDelta), .tempCycMin(tempCycMin),
    .intTemp(intTemp), .rxTemp(rxTemp), .rxTempValid(rxTempValid),
    .humValue(humValue), .humThrSel(humThrSel), .humCycSet(humCycSet),
    .limitCount(limitCount), .limitEval(limitEval), .ctrlMode(ctrlMode),
    .coolingOp(coolingOp), .actHeat(actHeat), .actCool(actCool),
    .roomTemp(roomTemp), .ctrlEnable(ctrlEnable), .tempSend(tempSend),
    .pollReq(pollReq), .humSend(humSend), .limitState(limitState),
    .limitSend(limitSend));
  rcv_thermo_model u_thermo (.clk_sys(clk_sys), .pollReq(pollReq),
    .sendNow(sendNow), .tempVal(16'h012c), .rxTemp(rxTemp),
    .rxTempValid(rxTempValid));
  // ****
  // shared tasks
  // ****
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic do_reset(input rcv_src_t src);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    tempSrc <= src;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask
  task automatic telegram();
    @(posedge clk_sys);
    sendNow <= 1'b1;
    @(posedge clk_sys);
    sendNow <= 1'b0;
    cyc(4);
  endtask
  task automatic set_temp(input logic [15:0] t);
    @(posedge clk_sys);
    intTemp <= t;
    cyc(5);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_internal();
    int s0;
    do_reset(SRC_INTERNAL);
    cyc(2);
    check("ctrlEnable", 16'(ctrlEnable), 16'h0001);
    check("roomTemp", roomTemp, 16'h00c8);
    cyc(4);
    s0 = sends;
    set_temp(16'h00ca);
    check("sends small", 16'(sends - s0), 16'h0000);
    set_temp(16'h00cb);
    check("sends delta", 16'(sends - s0), 16'h0001);
    set_temp(16'h00cd);
    check("sends ref", 16'(sends - s0), 16'h0001);
    set_temp(16'h00c8);
  endtask
  task automatic t_received();
    rxCalib <= 8'hf6;
    do_reset(SRC_RECEIVED);
    cyc(30);
    check("ctrlEnable wait", 16'(ctrlEnable), 16'h0000);
    telegram();
    check("ctrlEnable go", 16'(ctrlEnable), 16'h0001);
    check("roomTemp calib", roomTemp, 16'h0122);
    rxCalib <= 8'h00;
  endtask
  task automatic t_blend();
    int w;
    do_reset(SRC_BOTH);
    telegram();
    for (int i = 0; i < 10; i++) begin
      w = (i == 0) ? 5 : i;
      @(posedge clk_sys);
      blendWeight <= 4'(i);
      cyc(4);
      check("roomTemp blend", roomTemp, 16'(300 - 10 * w));
    end
  endtask
  task automatic t_humidity();
    int h0;
    h0 = hsends;
    do_reset(SRC_INTERNAL);
    cyc(4);
    check("humSend first", 16'(hsends - h0), 16'h0001);
    @(posedge clk_sys);
    humValue <= 10'h000;
    cyc(5);
    check("humSend delay", 16'(hsends - h0), 16'h0001);
    check("pollReq off", 16'(polls), 16'h0000);
    @(posedge clk_sys);
    humValue <= 10'h1f4;
  endtask
  task automatic enter_prot(input logic [1:0] ev, input logic cool);
    @(posedge clk_sys);
    ctrlMode <= OM_COMFORT;
    limitEval <= ev;
    coolingOp <= cool;
    cyc(3);
    @(posedge clk_sys);
    ctrlMode <= OM_PROTECT;
    cyc(1);
  endtask
  task automatic t_limits();
    rcv_pact_t a;
    logic on, tx;
    do_reset(SRC_INTERNAL);
    for (int i = 0; i < 5; i++) begin
      a = rcv_pact_t'(i);
      on = (a == PA_SEND_ON || a == PA_SET_ON);
      tx = (a == PA_SEND_ON || a == PA_SEND_OFF);
      actHeat <= a;
      enter_prot(2'h1, 1'b0);
      check("limitSend", 16'(limitSend), tx ? 16'h3 : 16'h0);
      check("limitState", 16'(limitState),
        a == PA_NONE ? 16'h1 : on ? 16'h3 : 16'h0);
    end
    actHeat <= PA_SEND_ON;
    enter_prot(2'h1, 1'b0);
    limitEval <= 2'h2;
    cyc(3);
    check("limitState held", 16'(limitState), 16'h3);
    coolingOp <= 1'b1;
    cyc(2);
    check("limitState cool", 16'(limitState), 16'h0);
    @(posedge clk_sys);
    ctrlMode <= OM_NIGHT;
    cyc(3);
    check("limitState back", 16'(limitState), 16'h2);
    limitCount <= 2'h1;
    enter_prot(2'h0, 1'b0);
    check("limitSend one", 16'(limitSend), 16'h1);
    actHeat <= PA_NONE;
    enter_prot(2'h0, 1'b0);
    limitEval <= 2'h1;
    cyc(3);
    check("limitState none", 16'(limitState), 16'h1);
  endtask
  initial begin
    #(40 * 5000);
    fail_count++;
    wrap_up();
  end
  initial begin
    t_internal();
    t_received();
    t_blend();
    t_humidity();
    t_limits();
    wrap_up();
  end
endmodule
